// ===== rtl/mpw_wakeup.sv
// Purpose: Multi-pin wakeup: edge flags, wake and shared interrupt request
// Assumes: Registers sit on the core data bus; enables come from other registers
// Notes: Read data appears one cycle after the read strobe
//
// What this block does
// RQ1: A pin edge sets its pending flag only when its enable bit is one.
// RQ2: An edge-select bit of one picks falling edges, zero picks rising edges.
// RQ3: All pending flags are ORed to drive wake in low-power mode and the interrupt.
// RQ4: The shared interrupt request is raised only while the wake interrupt enable is one.
// RQ5: A halt or idle command is ignored while any pending flag is set.
// RQ6: While a flag stays set and interrupts are enabled, the request holds and blocks others.
// RQ7: Writing zero to a pending bit clears it, writing one keeps it, writes never set it.
// RQ8: A bit clear reads all bits in cycle one and writes them back changed in cycle two.
// RQ9: With several pins enabled software clears flags by direct mask write, not bit clear.
// RQ10: When comparator select is one, the filter output replaces pin 6 as wake source.
// RQ11: Software using the filter output sets enable bit 6 and clears edge-select bit 6.
// RQ12: Edge detection works the same whether a pin is an input or an output.
// RQ13: Software makes wake pins inputs, since an output pin never leaves low power.
// RQ14: Reset clears enable, edge-select and pending registers to zero.
// RQ15: Enable, edge-select and pending are eight bits with bit n for pin n.
// RQ16: The core takes the interrupt only while its global mask flag is set.
// RQ17: Pins are synchronised and edges found by comparing samples; set beats clear.
`timescale 1ns/1ps
module mpw_wakeup
    import mpw_pkg::*;
#(
    parameter int PIN_COUNT = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire mpw_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    input wire mpw_bitclr_req_s bitclr_req,
    output logic bitclr_busy,
    input wire logic [PIN_COUNT-1:0] port_pin,
    input wire logic comparator_filter_output,
    input wire logic comparator_interrupt_select,
    input wire logic wake_interrupt_enable,
    input wire logic global_int_mask,
    input wire logic low_power_mode,
    input wire logic low_power_request,
    output logic low_power_accept,
    output logic wake_output,
    output logic edge_interrupt_request,
    output logic edge_interrupt_take,
    output logic other_int_block
);

    // Pin 6 must exist for the comparator path; refused at elaboration
    if (PIN_COUNT < 7 || PIN_COUNT > MPW_REG_WIDTH)
    begin : g_bad_pin_count
        $error("PIN_COUNT must be 7 or 8");
    end

    logic [PIN_COUNT-1:0] pin_lvl;
    logic [PIN_COUNT-1:0] src_lvl;
    logic [PIN_COUNT-1:0] prev_ff;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    logic [PIN_COUNT-1:0] edge_hit;
    logic [PIN_COUNT-1:0] enable_ff;
    logic [PIN_COUNT-1:0] edge_sel_ff;
    logic [PIN_COUNT-1:0] pend_ff;
    logic [PIN_COUNT-1:0] nxt_enable;
    logic [PIN_COUNT-1:0] nxt_edge_sel;
    logic [PIN_COUNT-1:0] nxt_pend;
    logic [PIN_COUNT-1:0] clr_mask;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] bc_data_ff;
    logic [7:0] nxt_bc_data;
    logic [7:0] bc_addr_ff;
    logic [7:0] nxt_bc_addr;
    logic [2:0] bc_idx_ff;
    logic [2:0] nxt_bc_idx;
    mpw_bitclr_state_e bc_state_ff;
    mpw_bitclr_state_e nxt_bc_state;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] bc_wdata;
    logic any_pend;

    // Pin synchronisers; pin pad direction is not seen here
    mpw_pin_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_async(port_pin),
        .level(pin_lvl)
    );

    // Wake source mux; filter output is already on clk
    always_comb
    begin
        src_lvl = pin_lvl;
        if (comparator_interrupt_select) // [RQ10]
        begin
            src_lvl[MPW_COMPARATOR_BIT] = comparator_filter_output;
        end
    end

    // Edge detection against the previous sample
    assign rise = src_lvl & ~prev_ff; // [RQ17] [RQ12]
    assign fall = ~src_lvl & prev_ff;
    assign edge_hit = enable_ff & ((edge_sel_ff & fall) | (~edge_sel_ff & rise)); // [RQ1] [RQ2]

    // Bit-clear write-back image with the target bit cleared
    always_comb
    begin
        bc_wdata = bc_data_ff;
        bc_wdata[bc_idx_ff] = 1'b0;
    end

    // Write port: direct bus write or bit-clear write-back
    always_comb
    begin
        if (bc_state_ff == MPW_BC_WRITE) // [RQ8]
        begin
            wr_en = 1'b1;
            wr_addr = bc_addr_ff;
            wr_data = bc_wdata;
        end
        else
        begin
            wr_en = bus_req.wr_en;
            wr_addr = bus_req.addr;
            wr_data = bus_req.wdata;
        end
    end

    // Register file next values
    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_edge_sel = edge_sel_ff;
        clr_mask = '0;
        if (wr_en)
        begin
            if (wr_addr == MPW_ADDR_ENABLE)
            begin
                nxt_enable = wr_data[PIN_COUNT-1:0];
            end
            else if (wr_addr == MPW_ADDR_EDGE_SELECT)
            begin
                nxt_edge_sel = wr_data[PIN_COUNT-1:0];
            end
            else if (wr_addr == MPW_ADDR_PENDING)
            begin
                clr_mask = ~wr_data[PIN_COUNT-1:0]; // [RQ7]
            end
        end
        nxt_pend = (pend_ff & ~clr_mask) | edge_hit; // [RQ7] [RQ17]
    end

    // Read mux, registered; unused upper bits read zero
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (bus_req.rd_en)
        begin
            if (bus_req.addr == MPW_ADDR_ENABLE)
            begin
                nxt_rdata = 8'(enable_ff); // [RQ15]
            end
            else if (bus_req.addr == MPW_ADDR_EDGE_SELECT)
            begin
                nxt_rdata = 8'(edge_sel_ff);
            end
            else if (bus_req.addr == MPW_ADDR_PENDING)
            begin
                nxt_rdata = 8'(pend_ff);
            end
            else
            begin
                nxt_rdata = 8'h00;
            end
        end
    end

    // Bit-clear sequencer: read cycle captures all bits
    always_comb
    begin
        nxt_bc_state = bc_state_ff;
        nxt_bc_data = bc_data_ff;
        nxt_bc_addr = bc_addr_ff;
        nxt_bc_idx = bc_idx_ff;
        case (bc_state_ff)
            MPW_BC_READ:
            begin
                if (bitclr_req.start)
                begin
                    nxt_bc_addr = bitclr_req.addr;
                    nxt_bc_idx = bitclr_req.bit_idx;
                    nxt_bc_state = MPW_BC_WRITE; // [RQ8]
                    if (bitclr_req.addr == MPW_ADDR_ENABLE)
                    begin
                        nxt_bc_data = 8'(enable_ff);
                    end
                    else if (bitclr_req.addr == MPW_ADDR_EDGE_SELECT)
                    begin
                        nxt_bc_data = 8'(edge_sel_ff);
                    end
                    else if (bitclr_req.addr == MPW_ADDR_PENDING)
                    begin
                        nxt_bc_data = 8'(pend_ff);
                    end
                    else
                    begin
                        nxt_bc_data = 8'h00;
                    end
                end
            end
            MPW_BC_WRITE:
            begin
                nxt_bc_state = MPW_BC_READ;
            end
            default:
            begin
                nxt_bc_state = MPW_BC_READ;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enable_ff <= MPW_RST_ENABLE[PIN_COUNT-1:0]; // [RQ14]
            edge_sel_ff <= MPW_RST_EDGE_SELECT[PIN_COUNT-1:0]; // [RQ14]
            pend_ff <= MPW_RST_PENDING[PIN_COUNT-1:0]; // [RQ14]
            prev_ff <= '0;
            rdata_ff <= 8'h00;
            bc_state_ff <= MPW_BC_READ;
            bc_data_ff <= 8'h00;
            bc_addr_ff <= 8'h00;
            bc_idx_ff <= 3'h0;
        end
        else
        begin
            enable_ff <= nxt_enable;
            edge_sel_ff <= nxt_edge_sel;
            pend_ff <= nxt_pend;
            prev_ff <= src_lvl;
            rdata_ff <= nxt_rdata;
            bc_state_ff <= nxt_bc_state;
            bc_data_ff <= nxt_bc_data;
            bc_addr_ff <= nxt_bc_addr;
            bc_idx_ff <= nxt_bc_idx;
        end
    end

    // Combined flag and its consumers
    assign any_pend = |pend_ff; // [RQ3]
    assign wake_output = any_pend & low_power_mode; // [RQ3]
    assign edge_interrupt_request = any_pend & wake_interrupt_enable; // [RQ4] [RQ6]
    assign edge_interrupt_take = edge_interrupt_request & global_int_mask; // [RQ16]
    assign other_int_block = edge_interrupt_request; // [RQ6]
    assign low_power_accept = low_power_request & ~any_pend; // [RQ5]
    assign bus_rdata = rdata_ff;
    assign bitclr_busy = (bc_state_ff == MPW_BC_WRITE);

endmodule

// ===== rtl/mpw_pkg.sv
// Purpose: Shared constants and types for the multi-pin wakeup unit
// Assumes: 8-bit core data bus, 8-bit register addresses
// Notes: Offsets are the core's data-space addresses
package mpw_pkg;

    // Register addresses on the core data bus
    localparam logic [7:0] MPW_ADDR_EDGE_SELECT = 8'hAF;
    localparam logic [7:0] MPW_ADDR_PENDING = 8'hB0;
    localparam logic [7:0] MPW_ADDR_ENABLE = 8'hB1;

    // Values after reset
    localparam logic [7:0] MPW_RST_EDGE_SELECT = 8'h00;
    localparam logic [7:0] MPW_RST_PENDING = 8'h00;
    localparam logic [7:0] MPW_RST_ENABLE = 8'h00;

    // Field positions
    localparam int MPW_COMPARATOR_BIT = 6;
    localparam int MPW_REG_WIDTH = 8;

    // Bit-clear instruction: read cycle, then write-back cycle
    localparam int MPW_BITCLR_CYCLES = 2;

    // Core data bus access
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mpw_bus_req_s;

    // Bit-clear instruction request
    typedef struct packed {
        logic start;
        logic [7:0] addr;
        logic [2:0] bit_idx;
    } mpw_bitclr_req_s;

    typedef enum logic {
        MPW_BC_READ,
        MPW_BC_WRITE
    } mpw_bitclr_state_e;

endpackage

// ===== rtl/mpw_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to clk
// Notes: Level changes only when stages two and three agree
`timescale 1ns/1ps
module mpw_pin_sync
    import mpw_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] lvl_ff;
    logic [WIDTH-1:0] nxt_lvl;

    // Accept a level once the two later stages match
    always_comb
    begin
        nxt_lvl = lvl_ff;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (s2_ff[i] == s3_ff[i])
            begin
                nxt_lvl[i] = s3_ff[i];
            end
        end
    end

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
        end
        else
        begin
            s1_ff <= pin_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level = lvl_ff;

endmodule

// ===== tb/mpw_wakeup_props.sv
// Purpose: Port checks for the multi-pin wakeup unit
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every mpw_wakeup instance
`timescale 1ns/1ps
module mpw_wakeup_props
    import mpw_pkg::*;
#(
    parameter int PIN_COUNT = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire mpw_bus_req_s bus_req,
    input wire mpw_bitclr_req_s bitclr_req,
    input wire logic bitclr_busy,
    input wire logic wake_interrupt_enable,
    input wire logic global_int_mask,
    input wire logic low_power_mode,
    input wire logic low_power_request,
    input wire logic low_power_accept,
    input wire logic wake_output,
    input wire logic edge_interrupt_request,
    input wire logic edge_interrupt_take,
    input wire logic other_int_block
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Bit clear: accepted start, then one write-back cycle
    sequence s_bc_start;
        bitclr_req.start && !bitclr_busy;
    endsequence
    sequence s_bc_wb;
        bitclr_busy ##1 !bitclr_busy;
    endsequence
    a_bitclr_steps: assert property (s_bc_start |=> s_bc_wb)
        else $error("bit clear write-back not one cycle");
    a_irq_needs_en: assert property (edge_interrupt_request |-> wake_interrupt_enable)
        else $error("request without enable");
    a_take_needs_mask: assert property (edge_interrupt_take ==
        (edge_interrupt_request && global_int_mask)) else $error("take mismatch");
    a_block_follows: assert property (other_int_block == edge_interrupt_request)
        else $error("block differs from request");
    a_sleep_refused: assert property (edge_interrupt_request |-> !low_power_accept)
        else $error("low power accepted with flag set");
    a_wake_mode_only: assert property (wake_output |-> low_power_mode)
        else $error("wake outside low power");
    a_wake_irq_agree: assert property (low_power_mode && wake_interrupt_enable
        |-> wake_output == edge_interrupt_request) else $error("wake and request differ");
    a_flag_sticky: assert property (edge_interrupt_request && !bus_req.wr_en
        && !bitclr_busy |=> edge_interrupt_request || !wake_interrupt_enable)
        else $error("flag dropped without write");
    a_accept_no_req: assert property (low_power_accept |-> low_power_request)
        else $error("accept without request");
endmodule

bind mpw_wakeup mpw_wakeup_props #(.PIN_COUNT(PIN_COUNT)) u_props (.clk, .rst, .bus_req,
    .bitclr_req, .bitclr_busy, .wake_interrupt_enable, .global_int_mask, .low_power_mode,
    .low_power_request, .low_power_accept, .wake_output, .edge_interrupt_request,
    .edge_interrupt_take, .other_int_block);

// ===== tb/mpw_far_side.sv
// Purpose: External pins and comparator filter driving the unit
// Assumes: Pins are always driven, inputs to the device
// Notes: Levels change one edge after the bench asks
`timescale 1ns/1ps
module mpw_far_side
(
    input wire logic clk,
    input wire logic [7:0] pin_level,
    input wire logic filt_level,
    output logic [7:0] port_pin,
    output logic comparator_filter_output
);
    // Pin pads act as inputs, driven from outside
    always_ff @(posedge clk)
    begin
        port_pin <= pin_level;
        comparator_filter_output <= filt_level; // Rising edge only used
    end
endmodule

// ===== tb/multi_pin_wakeup_tb_top.sv
// Purpose: Register-level tests of the wakeup unit
// Assumes: Clear by direct mask write, as software should, except one bit-clear test on pending and one on enable
// Notes: Pin flags need about five edges through the synchroniser
`timescale 1ns/1ps
module multi_pin_wakeup_tb_top
    import mpw_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mpw_bus_req_s bus_req = '0;
    mpw_bitclr_req_s bitclr_req = '0;
    logic [7:0] bus_rdata, port_pin, pin_level = 8'h00;
    logic filt_level = 1'b0;
    logic comparator_filter_output, comparator_interrupt_select = 1'b0;
    logic wake_interrupt_enable = 1'b0, global_int_mask = 1'b0;
    logic low_power_mode = 1'b0, low_power_request = 1'b0;
    logic bitclr_busy, low_power_accept, wake_output;
    logic edge_interrupt_request, edge_interrupt_take, other_int_block;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    mpw_far_side i_far (.clk, .pin_level, .filt_level, .port_pin, .comparator_filter_output);
    mpw_wakeup #(.PIN_COUNT(8)) i_dut (.clk, .rst, .bus_req, .bus_rdata, .bitclr_req,
        .bitclr_busy, .port_pin, .comparator_filter_output, .comparator_interrupt_select,
        .wake_interrupt_enable, .global_int_mask, .low_power_mode, .low_power_request,
        .low_power_accept, .wake_output, .edge_interrupt_request, .edge_interrupt_take,
        .other_int_block);
    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Register write, taken at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= {1'b0, 1'b1, a, d};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
    endtask
    // Register read, data valid the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        bus_req <= {1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk) chk(bus_rdata, exp, what);
        @(posedge clk);
    endtask
    // Cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(MPW_ADDR_EDGE_SELECT, 8'h00, "edge_sel");
        rd(MPW_ADDR_PENDING, 8'h00, "pending");
        rd(MPW_ADDR_ENABLE, 8'h00, "enable");
        rd(8'h55, 8'h00, "unmapped");
        wr(MPW_ADDR_EDGE_SELECT, 8'h0A);
        wr(MPW_ADDR_ENABLE, 8'h0F);
        rd(MPW_ADDR_ENABLE, 8'h0F, "enable");
        pin_level <= 8'h1F;
        repeat (8) @(posedge clk);
        rd(MPW_ADDR_PENDING, 8'h05, "rise");
        pin_level <= 8'h00;
        repeat (8) @(posedge clk);
        rd(MPW_ADDR_PENDING, 8'h0F, "fall");
        @(negedge clk) chk({7'h00, edge_interrupt_request}, 8'h00, "req_off");
        @(posedge clk);
        wake_interrupt_enable <= 1'b1;
        global_int_mask <= 1'b1;
        low_power_request <= 1'b1;
        low_power_mode <= 1'b1;
        @(negedge clk) chk({3'h0, edge_interrupt_request, edge_interrupt_take, other_int_block,
            low_power_accept, wake_output}, 8'h1D, "irq_set");
        @(posedge clk);
        global_int_mask <= 1'b0;
        @(negedge clk) chk({7'h00, edge_interrupt_take}, 8'h00, "take");
        @(posedge clk);
        wr(MPW_ADDR_PENDING, 8'hF7);
        rd(MPW_ADDR_PENDING, 8'h07, "clr0");
        wr(MPW_ADDR_PENDING, 8'hFF);
        rd(MPW_ADDR_PENDING, 8'h07, "keep1");
        bitclr_req <= {1'b1, MPW_ADDR_PENDING, 3'h0};
        @(posedge clk);
        bitclr_req <= '0;
        @(negedge clk) chk({7'h00, bitclr_busy}, 8'h01, "busy");
        repeat (2) @(posedge clk);
        rd(MPW_ADDR_PENDING, 8'h06, "bitclr");
        comparator_interrupt_select <= 1'b1;
        wr(MPW_ADDR_EDGE_SELECT, 8'h00);
        wr(MPW_ADDR_ENABLE, 8'h40);
        wr(MPW_ADDR_PENDING, 8'h00);
        filt_level <= 1'b1;
        repeat (4) @(posedge clk);
        rd(MPW_ADDR_PENDING, 8'h40, "filter");
        wr(MPW_ADDR_PENDING, 8'h00);
        @(negedge clk) chk({7'h00, low_power_accept}, 8'h01, "accept");
        // Bit clear of an enable bit; a bus write in the write-back cycle is dropped
        @(posedge clk);
        bitclr_req <= {1'b1, MPW_ADDR_ENABLE, 3'h6};
        @(posedge clk);
        bitclr_req <= '0;
        wr(MPW_ADDR_ENABLE, 8'hFF);
        rd(MPW_ADDR_ENABLE, 8'h00, "bitclr_en");
        wrap_up();
    end
endmodule
